// ===== design/tra_pkg.sv
/*
 * constants, types and register map of the timer register-a io control block.
 * assumes a single 10 mhz system clock and an 8-bit register port.
 */
package tra_pkg;

   // ************************************************************
   // register map (byte offsets on the 8-bit register port)
   // ************************************************************
   localparam logic [7:0] TRA_OFF_CH1_IO = 8'h00; // ch1_reg_a_io_control
   localparam logic [7:0] TRA_OFF_CH2_IO = 8'h01; // ch2_reg_a_io_control
   localparam logic [7:0] TRA_OFF_CH3_IO = 8'h02; // ch3_reg_a_io_control_high
   localparam logic [7:0] TRA_OFF_CH0_MODE = 8'h03; // ch0_mode_register
   localparam logic [7:0] TRA_OFF_CH0C_IO = 8'h04; // ch0 general reg c io control
   localparam logic [7:0] TRA_OFF_CH4_CTRL = 8'h05; // ch4_control_register
   localparam logic [7:0] TRA_OFF_INT_STAT = 8'h06; // sticky capture status, read only
   localparam logic [7:0] TRA_OFF_INT_EN = 8'h07; // interrupt enable
   localparam logic [7:0] TRA_OFF_INT_CLR = 8'h08; // write one to clear, write only

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int TRA_NCH = 4; // slot 0 is ch0 reg c, slots 1..3 are ch1..ch3 reg a
   localparam int TRA_SEL_MODE = 3; // io_select_bit3: 0 compare, 1 capture
   localparam int TRA_SEL_SRC = 2; // io_select_bit2: level or cascade source
   localparam int TRA_SEL_BOTH = 1; // io_select_bit1: both edges in capture
   localparam int TRA_SEL_FALL = 0; // io_select_bit0: falling edge in capture
   localparam int TRA_BFA_BIT = 0; // buffer_mode_a_enable in ch0_mode_register
   localparam logic [2:0] TRA_PSC_UNDIV = 3'h0; // prescaler code for undivided clock
   localparam logic [3:0] TRA_SEL_RST = 4'h0; // selector after reset
   localparam logic [3:0] TRA_FLAGS_RST = 4'h0; // status and enable after reset
   localparam logic [7:0] TRA_RDATA_IDLE = 8'h00; // read data outside a read cycle

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      TRA_ACT_OFF = 2'b00, // output disabled
      TRA_ACT_LOW = 2'b01, // drive 0 on match
      TRA_ACT_HIGH = 2'b10, // drive 1 on match
      TRA_ACT_TOG = 2'b11 // toggle on match
   } tra_act_t;

   typedef enum logic [1:0] {
      TRA_CASC_NONE = 2'b00, // no cascaded source
      TRA_CASC_CH0A = 2'b01, // ch0 reg a match or capture
      TRA_CASC_CH4 = 2'b10 // ch4 counter count activity
   } tra_casc_t;

   typedef struct packed {
      logic wr; // write strobe
      logic rd; // read strobe
      logic [7:0] addr; // register offset
      logic [7:0] wdata; // write data
   } tra_bus_t;

   typedef struct packed {
      logic out; // pin level
      logic oe_n; // low while the pin is driven
   } tra_pin_t;

   localparam logic [7:0] TRA_IO_OFF [TRA_NCH] = '{TRA_OFF_CH0C_IO, TRA_OFF_CH1_IO,
      TRA_OFF_CH2_IO, TRA_OFF_CH3_IO}; // selector offset per slot
   localparam tra_casc_t TRA_CASC_MAP [TRA_NCH] = '{TRA_CASC_NONE, TRA_CASC_CH0A,
      TRA_CASC_NONE, TRA_CASC_CH4}; // cascade source per slot

endpackage

// ===== design/tra_io_unit.sv
/*
 * one io control slot: selector, pin output logic and capture trigger.
 * assumes pin_in is asynchronous and all other inputs are on sys_clk.
 */
`timescale 1ns/10ps
module tra_io_unit
   import tra_pkg::*;
#(
   parameter tra_casc_t CASC = TRA_CASC_NONE // cascade source of this slot
)
(
   input logic sys_clk, // system clock
   input logic rstn, // async reset, low active
   input logic ce, // clock enable, freezes state
   input logic wr_en, // selector write this cycle
   input logic [3:0] wr_sel, // new selector value
   input logic pin_in, // raw pin level
   input logic cmp_match, // compare match pulse
   input logic casc_evt, // cascaded capture event
   input logic inhibit, // slot used as buffer
   output logic [3:0] sel_r, // selector for readback
   output tra_pin_t pin_r, // registered pin drive
   output logic capt_r // capture strobe
);

   // ************************************************************
   // state
   // ************************************************************
   logic [3:0] sel_nxt; // next selector
   tra_pin_t pin_nxt; // next pin drive
   logic capt_nxt; // next capture strobe
   logic meta_r; // first sync stage, read only by sync_r
   logic sync_r; // synchronised pin
   logic prev_r; // synchronised pin, one cycle older
   logic rise; // rising edge seen
   logic fall; // falling edge seen
   logic edge_hit; // selected edge seen
   logic pin_cap; // capture from own pin
   logic casc_cap; // capture from cascade source
   tra_act_t act; // match action of compare mode

   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
   assign act = tra_act_t'(sel_r[TRA_SEL_BOTH:TRA_SEL_FALL]);
   assign pin_cap = sel_r[TRA_SEL_MODE] & ~sel_r[TRA_SEL_SRC];
   assign casc_cap = sel_r[TRA_SEL_MODE] & sel_r[TRA_SEL_SRC] & (CASC != TRA_CASC_NONE);

   // ************************************************************
   // next state
   // ************************************************************
   // edge choice: bit1 set means both edges, else bit0 picks falling
   always_comb
   begin
      edge_hit = sel_r[TRA_SEL_BOTH] ? (rise | fall) : (sel_r[TRA_SEL_FALL] ? fall : rise); // R2
   end

   // selector, pin drive and capture
   always_comb
   begin
      sel_nxt = wr_en ? wr_sel : sel_r;
      pin_nxt = pin_r;
      // a buffer slot neither drives nor captures
      if (inhibit)
      begin
         pin_nxt.oe_n = 1'b1; // R6
      end
      else if (wr_en && !wr_sel[TRA_SEL_MODE])
      begin
         // initial level appears at once, before any match
         pin_nxt.out = wr_sel[TRA_SEL_SRC]; // R8
         pin_nxt.oe_n = (wr_sel[TRA_SEL_BOTH:TRA_SEL_FALL] == TRA_ACT_OFF); // R1
      end
      else if (wr_en)
      begin
         pin_nxt.oe_n = 1'b1; // capture mode releases the pin
      end
      else if (!sel_r[TRA_SEL_MODE] && cmp_match)
      begin
         unique case (act)
            TRA_ACT_OFF: pin_nxt.out = pin_r.out; // R1
            TRA_ACT_LOW: pin_nxt.out = 1'b0; // R1
            TRA_ACT_HIGH: pin_nxt.out = 1'b1; // R1
            TRA_ACT_TOG: pin_nxt.out = ~pin_r.out; // R1
         endcase
      end
      // own pin edge, or cascade event where this slot has one
      capt_nxt = ~inhibit & ((pin_cap & edge_hit) | (casc_cap & casc_evt)); // R3
   end

   // registers only
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sel_r <= TRA_SEL_RST;
         pin_r <= '{out: 1'b0, oe_n: 1'b1};
         capt_r <= 1'b0;
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else if (ce)
      begin
         sel_r <= sel_nxt;
         pin_r <= pin_nxt;
         capt_r <= capt_nxt;
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_toggle; // R1
      @(posedge sys_clk) disable iff (!rstn)
      (ce && !inhibit && !wr_en && !sel_r[TRA_SEL_MODE] && act == TRA_ACT_TOG && cmp_match)
      |=> (pin_r.out != $past(pin_r.out)) && !pin_r.oe_n;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle on match missed"); // R1

   property p_fall_only; // R2
      @(posedge sys_clk) disable iff (!rstn)
      (ce && !inhibit && pin_cap && sel_r[TRA_SEL_BOTH:TRA_SEL_FALL] == 2'b01 && rise)
      |=> !capt_r;
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("capture on wrong edge"); // R2

   property p_pin_edge; // R3
      @(posedge sys_clk) disable iff (!rstn)
      (ce && !inhibit && pin_cap && sel_r[TRA_SEL_BOTH] && (rise || fall)) |=> capt_r;
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pin edge capture missed"); // R3

   property p_inhibit; // R6
      @(posedge sys_clk) disable iff (!rstn)
      (ce && inhibit) |=> !capt_r && pin_r.oe_n;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("buffer slot still active"); // R6

   property p_init_level; // R8
      @(posedge sys_clk) disable iff (!rstn)
      (ce && !inhibit && wr_en && !wr_sel[TRA_SEL_MODE]) |=> pin_r.out == $past(wr_sel[TRA_SEL_SRC]);
   endproperty
   a_init_level: assert property (p_init_level) else $error("initial level not driven"); // R8

   c_toggle: cover property (@(posedge sys_clk) disable iff (!rstn)
      ce && act == TRA_ACT_TOG && cmp_match && !sel_r[TRA_SEL_MODE]);
   c_pin_capt: cover property (@(posedge sys_clk) disable iff (!rstn) capt_r && pin_cap);

endmodule

// ===== design/tra_ctrl.sv
/*
 * top of the timer register-a io control block: register port, four io slots,
 * cascade routing and the capture interrupt.
 * assumes compare match, ch0 reg a event and ch4 count pulses come from timer
 * logic on sys_clk, and that the pins are asynchronous.
 */
`timescale 1ns/10ps

// Overview of operation
// R1: bit3 low: compare, initial level, match action
// R2: bit3 high, bit2 low: capture on chosen edge
// R3: pin capture uses the channel's own pin
// R4: ch1 cascade captures on ch0 reg a events
// R5: ch3 cascade captures on ch4 count activity
// R6: buffered ch0 reg c: no capture, no compare
// R7: undivided ch4 clock gives no cascaded capture
// R8: compare write drives initial level at once
module tra_ctrl
   import tra_pkg::*;
(
   input logic sys_clk, // system clock, 10 mhz
   input logic rstn, // async reset, low active
   input logic ce, // clock enable, freezes state
   input tra_bus_t bus, // register port request
   output logic [7:0] bus_rdata, // read data, cycle after read
   input logic [TRA_NCH-1:0] cmp_match, // compare match per slot
   input logic ch0a_evt, // ch0 reg a match or capture
   input logic ch4_tick, // ch4 counter counted
   input logic [TRA_NCH-1:0] pin_in, // raw timer pins per slot
   output logic [TRA_NCH-1:0] pin_out, // timer pin level per slot
   output logic [TRA_NCH-1:0] pin_oe_n, // low while pin is driven
   output logic [TRA_NCH-1:0] capt, // capture strobe per slot
   output logic irq // capture interrupt, level
);

   // ************************************************************
   // register state
   // ************************************************************
   logic bfa_r; // buffer_mode_a_enable of ch0
   logic bfa_nxt; // next buffer mode
   logic [2:0] psc_r; // ch4 prescaler select field
   logic [2:0] psc_nxt; // next prescaler field
   logic [3:0] stat_r; // sticky capture status
   logic [3:0] stat_nxt; // next status
   logic [3:0] en_r; // interrupt enable
   logic [3:0] en_nxt; // next enable
   logic [7:0] rdata_r; // registered read data
   logic [7:0] rdata_nxt; // next read data
   logic irq_r; // registered interrupt
   logic irq_nxt; // next interrupt
   logic [3:0] clr; // status bits cleared this cycle

   // ************************************************************
   // slot wiring
   // ************************************************************
   logic [TRA_NCH-1:0] wr_en; // selector write per slot
   logic [TRA_NCH-1:0] casc_evt; // cascade event per slot
   logic [TRA_NCH-1:0] inhibit; // slot disabled as buffer
   logic [TRA_NCH-1:0] capt_w; // capture strobes from slots
   logic [3:0] sel_w [TRA_NCH]; // selectors from slots
   tra_pin_t pin_w [TRA_NCH]; // pin drive from slots
   logic ch4_live; // ch4 counts on a divided clock

   // an undivided ch4 clock would count every cycle; cascading is then off
   assign ch4_live = (psc_r != TRA_PSC_UNDIV); // R7

   // per-slot decode and cascade sources
   always_comb
   begin
      for (int i = 0; i < TRA_NCH; i++)
      begin
         wr_en[i] = bus.wr && (bus.addr == TRA_IO_OFF[i]);
         inhibit[i] = 1'b0;
         unique case (TRA_CASC_MAP[i])
            TRA_CASC_CH0A: casc_evt[i] = ch0a_evt; // R4
            TRA_CASC_CH4: casc_evt[i] = ch4_tick & ch4_live; // R5
            TRA_CASC_NONE: casc_evt[i] = 1'b0;
            default: casc_evt[i] = 1'b0;
         endcase
      end
      // only ch0 reg c can act as a buffer register
      inhibit[0] = bfa_r; // R6
   end

   // ************************************************************
   // io slots
   // ************************************************************
   // one slot per controlled register; the cascade source is fixed per slot
   generate
      for (genvar g = 0; g < TRA_NCH; g++)
      begin : g_slot
         tra_io_unit #(
            .CASC(TRA_CASC_MAP[g])
         ) u_slot (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .ce(ce),
            .wr_en(wr_en[g]),
            .wr_sel(bus.wdata[3:0]),
            .pin_in(pin_in[g]),
            .cmp_match(cmp_match[g]),
            .casc_evt(casc_evt[g]),
            .inhibit(inhibit[g]),
            .sel_r(sel_w[g]),
            .pin_r(pin_w[g]),
            .capt_r(capt_w[g])
         );
         assign pin_out[g] = pin_w[g].out;
         assign pin_oe_n[g] = pin_w[g].oe_n;
      end
   endgenerate

   assign capt = capt_w;

   // ************************************************************
   // register port
   // ************************************************************
   // writes to control and interrupt registers
   always_comb
   begin
      bfa_nxt = bfa_r;
      psc_nxt = psc_r;
      en_nxt = en_r;
      clr = TRA_FLAGS_RST;
      if (bus.wr)
      begin
         unique case (bus.addr)
            TRA_OFF_CH0_MODE: bfa_nxt = bus.wdata[TRA_BFA_BIT];
            TRA_OFF_CH4_CTRL: psc_nxt = bus.wdata[2:0];
            TRA_OFF_INT_EN: en_nxt = bus.wdata[3:0];
            TRA_OFF_INT_CLR: clr = bus.wdata[3:0];
            default: ; // selectors, status register or unmapped
         endcase
      end
      // a capture in the clearing cycle survives the clear
      stat_nxt = (stat_r & ~clr) | capt_w;
      irq_nxt = |(stat_nxt & en_nxt);
   end

   // read mux; data stand only in the cycle after the strobe
   always_comb
   begin
      rdata_nxt = TRA_RDATA_IDLE;
      if (bus.rd)
      begin
         for (int i = 0; i < TRA_NCH; i++)
         begin
            if (bus.addr == TRA_IO_OFF[i])
            begin
               rdata_nxt = {4'h0, sel_w[i]};
            end
         end
         unique case (bus.addr)
            TRA_OFF_CH0_MODE: rdata_nxt = {7'h00, bfa_r};
            TRA_OFF_CH4_CTRL: rdata_nxt = {5'h00, psc_r};
            TRA_OFF_INT_STAT: rdata_nxt = {4'h0, stat_r};
            TRA_OFF_INT_EN: rdata_nxt = {4'h0, en_r};
            default: ; // selectors, clear register and unmapped
         endcase
      end
   end

   // registers only
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bfa_r <= 1'b0;
         psc_r <= TRA_PSC_UNDIV;
         stat_r <= TRA_FLAGS_RST;
         en_r <= TRA_FLAGS_RST;
         rdata_r <= TRA_RDATA_IDLE;
         irq_r <= 1'b0;
      end
      else if (ce)
      begin
         bfa_r <= bfa_nxt;
         psc_r <= psc_nxt;
         stat_r <= stat_nxt;
         en_r <= en_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign bus_rdata = rdata_r;
   assign irq = irq_r;

   // ************************************************************
   // checks
   // ************************************************************
   // all checks sample on sys_clk and rest while reset is low
   // ch1 captures on every ch0 reg a event
   property p_ch1_casc; // R4
      @(posedge sys_clk) disable iff (!rstn)
      (ce && sel_w[1][TRA_SEL_MODE] && sel_w[1][TRA_SEL_SRC] && ch0a_evt) |=> capt[1];
   endproperty
   a_ch1_casc: assert property (p_ch1_casc) else $error("ch1 cascade capture missed"); // R4

   // ch3 captures on each divided ch4 count
   property p_ch3_casc; // R5
      @(posedge sys_clk) disable iff (!rstn)
      (ce && sel_w[3][TRA_SEL_MODE] && sel_w[3][TRA_SEL_SRC] && ch4_tick
       && psc_r != TRA_PSC_UNDIV) |=> capt[3];
   endproperty
   a_ch3_casc: assert property (p_ch3_casc) else $error("ch3 cascade capture missed"); // R5

   // undivided ch4 clock never cascades
   property p_ch3_undiv; // R7
      @(posedge sys_clk) disable iff (!rstn)
      (ce && sel_w[3][TRA_SEL_MODE] && sel_w[3][TRA_SEL_SRC] && psc_r == TRA_PSC_UNDIV)
      |=> !capt[3];
   endproperty
   a_ch3_undiv: assert property (p_ch3_undiv) // R7
      else $error("cascade capture on undivided clock");

   // buffered ch0 reg c stays silent
   property p_buf_quiet; // R6
      @(posedge sys_clk) disable iff (!rstn)
      (ce && bfa_r) [*2] |=> !capt[0] && pin_oe_n[0];
   endproperty
   a_buf_quiet: assert property (p_buf_quiet) else $error("buffered ch0 reg c active"); // R6

   // ch2 has no cascade source at all
   property p_ch2_no_casc; // R4
      @(posedge sys_clk) disable iff (!rstn)
      (ce && sel_w[2][TRA_SEL_MODE] && sel_w[2][TRA_SEL_SRC]) |=> !capt[2];
   endproperty
   a_ch2_no_casc: assert property (p_ch2_no_casc) else $error("ch2 has no cascade source"); // R4

   // enabled capture raises the interrupt
   property p_irq; // R2
      @(posedge sys_clk) disable iff (!rstn)
      (ce && capt[1] && en_nxt[1]) |=> stat_r[1] && irq;
   endproperty
   a_irq: assert property (p_irq) else $error("capture did not raise interrupt"); // R2

   // a capture in the clearing cycle survives
   property p_set_wins; // R2
      @(posedge sys_clk) disable iff (!rstn)
      (ce && (|capt)) |=> (stat_r & $past(capt)) == $past(capt);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("capture lost in status"); // R2

   // write-one clear with no capture beside it
   property p_clr;
      @(posedge sys_clk) disable iff (!rstn)
      (ce && bus.wr && bus.addr == TRA_OFF_INT_CLR && capt == 4'h0)
      |=> (stat_r & $past(bus.wdata[3:0])) == 4'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("status bit not cleared");

   // level interrupt follows enabled status
   property p_irq_level;
      @(posedge sys_clk) disable iff (!rstn)
      irq == |(stat_r & en_r);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   // read data stand one cycle, then idle
   property p_rdata_idle;
      @(posedge sys_clk) disable iff (!rstn)
      (ce && !bus.rd) |=> bus_rdata == TRA_RDATA_IDLE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

   // status read shows flags as they stood at the strobe
   property p_stat_rd;
      @(posedge sys_clk) disable iff (!rstn)
      (ce && bus.rd && bus.addr == TRA_OFF_INT_STAT) |=> bus_rdata == {4'h0, $past(stat_r)};
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

   // clock enable low holds capture, pin and interrupt outputs
   property p_freeze;
      @(posedge sys_clk) disable iff (!rstn)
      !ce |=> $stable(capt) && $stable(pin_out) && $stable(pin_oe_n) && $stable(irq);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

   // a compare code with a match action drives at once
   property p_drive; // R1
      @(posedge sys_clk) disable iff (!rstn)
      (ce && wr_en[1] && !bus.wdata[TRA_SEL_MODE]
       && bus.wdata[TRA_SEL_BOTH:TRA_SEL_FALL] != TRA_ACT_OFF) |=> !pin_oe_n[1];
   endproperty
   a_drive: assert property (p_drive) else $error("compare pin not driven"); // R1

   // ch1 in cascade mode ignores its own pin
   property p_ch1_only_evt; // R4
      @(posedge sys_clk) disable iff (!rstn)
      (ce && sel_w[1][TRA_SEL_MODE] && sel_w[1][TRA_SEL_SRC] && !ch0a_evt) |=> !capt[1];
   endproperty
   a_ch1_only_evt: assert property (p_ch1_only_evt) else $error("ch1 cascade unasked"); // R4

   // main scenarios: both cascades and a cleared interrupt

   c_ch1_casc: cover property (@(posedge sys_clk) disable iff (!rstn)
      capt[1] && sel_w[1][TRA_SEL_SRC]);
   c_ch3_casc: cover property (@(posedge sys_clk) disable iff (!rstn)
      capt[3] && sel_w[3][TRA_SEL_SRC]);
   c_irq_clr: cover property (@(posedge sys_clk) disable iff (!rstn)
      irq ##1 !irq);

endmodule

// ===== bench/tra_far_model.sv
/*
 * far side of the io control block: timer pins and neighbouring channel events.
 * assumes the bench calls its tasks and that all changes follow a sys_clk edge.
 */
`timescale 1ns/10ps
module tra_far_model
(
   input wire logic sys_clk, // system clock
   output logic [3:0] pin_in, // timer pin levels
   output logic [3:0] cmp_match, // compare match pulses
   output logic ch0a_evt, // ch0 reg a event pulse
   output logic ch4_tick // ch4 count pulse
);
   // ************************************************************
   // idle state: pins low, no events
   // ************************************************************
   initial
   begin
      pin_in = 4'h0;
      cmp_match = 4'h0;
      ch0a_evt = 1'b0;
      ch4_tick = 1'b0;
   end

   // pin level change just after an edge, then held
   task automatic set_pin(input int s, input logic v);
      @(posedge sys_clk);
      pin_in[s] <= v;
   endtask

   // one-cycle pulse: 0..3 match per slot, 4 ch0 reg a, 5 ch4 tick
   task automatic pulse(input int k);
      @(posedge sys_clk);
      if (k < 4)
         cmp_match[k] <= 1'b1;
      else if (k == 4)
         ch0a_evt <= 1'b1;
      else
         ch4_tick <= 1'b1;
      @(posedge sys_clk);
      cmp_match <= 4'h0;
      ch0a_evt <= 1'b0;
      ch4_tick <= 1'b0;
   endtask
endmodule

// ===== bench/tra_ctrl_tb.sv
/*
 * self-checking bench of the register-a io control block.
 * assumes the far side model drives pins and events; the bench owns the port.
 */
`timescale 1ns/10ps
module tra_ctrl_tb;
   import tra_pkg::*;
   logic sys_clk; // 10 mhz clock
   logic rstn; // async reset, low active
   logic ce; // clock enable
   tra_bus_t bus; // register port request
   logic [7:0] bus_rdata; // read data
   logic [3:0] cmp_match, pin_in, pin_out, pin_oe_n, capt; // per slot signals
   logic ch0a_evt, ch4_tick, irq; // events and interrupt
   int n_errors; // mismatch count
   int compares; // comparison count
   logic [7:0] msk [7] = '{8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h01, 8'h07, 8'h0f}; // used bits
   logic [7:0] adr [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03, 8'h05, 8'h07}; // rw regs
   logic [3:0] c4; // selector code under test

   tra_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .bus(bus),
      .bus_rdata(bus_rdata), .cmp_match(cmp_match), .ch0a_evt(ch0a_evt),
      .ch4_tick(ch4_tick), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .capt(capt), .irq(irq));
   tra_far_model u_far (.sys_clk(sys_clk), .pin_in(pin_in), .cmp_match(cmp_match),
      .ch0a_evt(ch0a_evt), .ch4_tick(ch4_tick));

   // ************************************************************
   // clock, verdict and shared tasks
   // ************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   // one-cycle write; #1 lets that edge's updates land
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      bus <= '0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      chk("bus_rdata", e, bus_rdata);
   endtask

   // pin level and drive of one slot
   task automatic chk_pin(input int s, input logic o, input logic oe);
      chk("pin_out", {7'h0, o}, {7'h0, pin_out[s]});
      chk("pin_oe_n", {7'h0, oe}, {7'h0, pin_oe_n[s]});
   endtask

   // bounded window: counts capture pulses of one slot
   task automatic cnt_capt(input int s, input int n);
      int k;
      k = 0;
      #1;
      repeat (8)
      begin
         if (capt[s] === 1'b1)
            k++;
         @(posedge sys_clk);
         #1;
      end
      chk("capt_count", n[7:0], k[7:0]);
   endtask

   // whole-run limit, counts as a mismatch
   initial
   begin
      #5000000;
      n_errors++;
      report_and_stop;
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      n_errors = 0;
      compares = 0;
      rstn = 1'b0;
      ce = 1'b1;
      bus = '0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values, unmapped and read-only places
      chk("pin_oe_n", 8'h0f, {4'h0, pin_oe_n});
      chk("irq", 8'h00, {7'h0, irq});
      for (int a = 0; a < 10; a++)
         rd_reg(a[7:0], 8'h00);
      wr_reg(8'hf0, 8'hff);
      rd_reg(8'hf0, 8'h00);
      rd_reg(TRA_OFF_CH1_IO, 8'h00);
      wr_reg(TRA_OFF_INT_STAT, 8'hff);
      rd_reg(TRA_OFF_INT_STAT, 8'h00);
      // readback of every read-write register, unused bits read 0
      for (int i = 0; i < 7; i++)
      begin
         wr_reg(adr[i], 8'hff);
         rd_reg(adr[i], msk[i]);
         wr_reg(adr[i], 8'h00);
      end
      rd_reg(TRA_OFF_INT_CLR, 8'h00);
      // clock enable low: strobe lost
      @(posedge sys_clk);
      ce <= 1'b0;
      wr_reg(TRA_OFF_CH1_IO, 8'h05);
      chk("pin_oe_n", 8'h01, {7'h0, pin_oe_n[1]});
      @(posedge sys_clk);
      ce <= 1'b1;
      rd_reg(TRA_OFF_CH1_IO, 8'h00);
      // every compare code: initial level, then match action
      for (int c = 8; c < 32; c++)
      begin
         c4 = {1'b0, c[2:0]};
         wr_reg(TRA_IO_OFF[c / 8], {4'h0, c4});
         chk_pin(c / 8, c4[2], c4[1:0] == 2'b00);
         u_far.pulse(c / 8);
         #1;
         case (c4[1:0])
            2'b00: chk_pin(c / 8, c4[2], 1'b1);
            2'b01: chk_pin(c / 8, 1'b0, 1'b0);
            2'b10: chk_pin(c / 8, 1'b1, 1'b0);
            default: chk_pin(c / 8, ~c4[2], 1'b0);
         endcase
      end
      // pin capture: rising, falling, both edges on the own pin only
      for (int c = 8; c < 11; c++)
      begin
         wr_reg(TRA_OFF_CH1_IO, c[7:0]);
         u_far.set_pin(1, 1'b1);
         cnt_capt(1, (c != 9) ? 1 : 0);
         u_far.set_pin(1, 1'b0);
         cnt_capt(1, (c != 8) ? 1 : 0);
      end
      u_far.set_pin(2, 1'b1);
      cnt_capt(1, 0);
      u_far.set_pin(2, 1'b0);
      wr_reg(TRA_OFF_CH3_IO, 8'h0a);
      u_far.set_pin(3, 1'b1);
      cnt_capt(3, 1);
      u_far.set_pin(3, 1'b0);
      cnt_capt(3, 1);
      // cascades: ch1 on ch0 reg a, ch3 on ch4 ticks, ch2 none
      wr_reg(TRA_OFF_CH1_IO, 8'h0c);
      wr_reg(TRA_OFF_CH2_IO, 8'h0c);
      wr_reg(TRA_OFF_CH3_IO, 8'h0c);
      u_far.pulse(4);
      cnt_capt(1, 1);
      wr_reg(TRA_OFF_CH4_CTRL, 8'h01);
      u_far.pulse(5);
      cnt_capt(3, 1);
      u_far.pulse(5);
      cnt_capt(1, 0);
      u_far.pulse(4);
      cnt_capt(2, 0);
      wr_reg(TRA_OFF_CH4_CTRL, {5'h00, TRA_PSC_UNDIV});
      u_far.pulse(5);
      cnt_capt(3, 0);
      // buffered ch0 reg c: neither compare nor capture
      wr_reg(TRA_OFF_CH0_MODE, 8'h01);
      wr_reg(TRA_OFF_CH0C_IO, 8'h05);
      chk_pin(0, 1'b0, 1'b1);
      u_far.pulse(0);
      #1;
      chk("pin_oe_n", 8'h01, {7'h0, pin_oe_n[0]});
      wr_reg(TRA_OFF_CH0C_IO, 8'h08);
      u_far.set_pin(0, 1'b1);
      cnt_capt(0, 0);
      u_far.set_pin(0, 1'b0);
      cnt_capt(0, 0);
      wr_reg(TRA_OFF_CH0_MODE, 8'h00);
      wr_reg(TRA_OFF_CH0C_IO, 8'h08);
      u_far.set_pin(0, 1'b1);
      cnt_capt(0, 1);
      // interrupt: raise, mask, unmask, clear
      wr_reg(TRA_OFF_INT_CLR, 8'h0f);
      rd_reg(TRA_OFF_INT_STAT, 8'h00);
      wr_reg(TRA_OFF_INT_EN, 8'h02);
      u_far.pulse(4);
      cnt_capt(1, 1);
      chk("irq", 8'h01, {7'h0, irq});
      rd_reg(TRA_OFF_INT_STAT, 8'h02);
      wr_reg(TRA_OFF_INT_EN, 8'h00);
      chk("irq", 8'h00, {7'h0, irq});
      wr_reg(TRA_OFF_INT_EN, 8'h02);
      chk("irq", 8'h01, {7'h0, irq});
      wr_reg(TRA_OFF_INT_CLR, 8'h02);
      chk("irq", 8'h00, {7'h0, irq});
      rd_reg(TRA_OFF_INT_STAT, 8'h00);
      report_and_stop;
   end
endmodule
